// file: design/sfp_pkg.sv
// constants and types shared by the programmable-flag fifo
package sfp_pkg;
	localparam int DATA_W    = 18;
	localparam int OFF_W     = 12;
	localparam int CNT_W     = 13;
	localparam int DEF_DEPTH = 1024;
	localparam int MIN_DEPTH = 64;
	localparam int MAX_DEPTH = 4096;
	// bit positions in the synchronised pin bundle
	localparam int PIN_WCLK  = 0;
	localparam int PIN_RCLK  = 1;
	localparam int PIN_WEN   = 2;
	localparam int PIN_REN   = 3;
	localparam int PIN_OSEL  = 4;
	localparam int PIN_REPLAY = 5;
	localparam int PIN_FSYNC = 6;
	localparam int PIN_FIRST = 7;
	localparam int PIN_WCHAIN = 8;
	localparam int PIN_RCHAIN = 9;
	localparam int PIN_CASC  = 10;
	localparam int PIN_MRST  = 11;
	localparam int PIN_DATA  = 12;
	localparam int PIN_W     = PIN_DATA + DATA_W;
	// reset image of the bundle: enables inactive, master reset asserted
	localparam logic [PIN_W-1:0] PIN_INIT = 30'h0000000C;
	// default offsets per depth
	localparam logic [OFF_W-1:0] OFS_D64   = 12'h007;
	localparam logic [OFF_W-1:0] OFS_D256  = 12'h01F;
	localparam logic [OFF_W-1:0] OFS_D512  = 12'h03F;
	localparam logic [OFF_W-1:0] OFS_DBIG  = 12'h07F;

	typedef enum logic {
		OFS_EMPTY = 1'b0,
		OFS_FULL  = 1'b1
	} sfp_ofs_e;

	function automatic logic [OFF_W-1:0] sfp_default_offset(input int depth);
		logic [OFF_W-1:0] v;
		v = OFS_DBIG;
		if (depth == 64)
			v = OFS_D64;
		else if (depth == 256)
			v = OFS_D256;
		else if (depth == 512)
			v = OFS_D512;
		return v;
	endfunction
endpackage

// file: design/sfp_sync.sv
// two-stage synchroniser for a bundle of asynchronous pins
module sfp_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	// clock and reset
	input  wire logic         sys_clk,
	input  wire logic         resetn,
	// pins in, synchronised copy out
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	logic [W-1:0] stage1;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			stage1 <= INIT;
			sync   <= INIT;
		end else begin
			stage1 <= pin;
			sync   <= stage1;
		end
	end
endmodule

// file: design/sfp_mem.sv
// word storage with one write port and an unregistered read port
module sfp_mem #(
	parameter int DEPTH = 1024,
	parameter int WIDTH = 18,
	parameter int AW    = $clog2(DEPTH)
) (
	// clock
	input  wire logic             sys_clk,
	// write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// read port
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	// no reset on the array: contents are undefined until written
	always_ff @(posedge sys_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	assign rd_data = mem[rd_addr];
endmodule

// file: design/sfp_fifo.sv
// 18-bit fifo with programmable almost flags, retransmit and chaining
//
// What this block does
// - two 12-bit offsets loaded from data bits
// - offset writes alternate empty then full
// - interrupted programming resumes at next offset
// - select high returns to normal fifo traffic
// - decode select and write enable per edge
// - offset readback alternates on read edges
// - unprogrammed offsets take depth-based defaults
// - full flag low blocks fifo writes, not offset writes
// - full flag changes only on write edges
// - empty flag low blocks fifo reads, not offset readback
// - empty flag changes only on read or replay edges
// - almost flags compare count against offsets
// - synchronous mode times almost flags per clock
// - half flag low above half depth
// - replay rewinds read pointer, write kept
// - replay only outside depth expansion
// - after replay reads resend data in order
// - depth mode holds half flag high
// - master reset empties the fifo
// - empty fifo keeps last read word
module sfp_fifo
	import sfp_pkg::*;
#(
	parameter int DEPTH = sfp_pkg::DEF_DEPTH
) (
	// clock and system reset
	input  wire logic                       sys_clk,
	input  wire logic                       resetn,
	// write side pins
	input  wire logic                       write_clk,
	input  wire logic                       write_enable_n,
	input  wire logic [sfp_pkg::DATA_W-1:0] data_in,
	// read side pins
	input  wire logic                       read_clk,
	input  wire logic                       read_enable_n,
	output logic      [sfp_pkg::DATA_W-1:0] data_out,
	// control pins
	input  wire logic                       master_reset_n,
	input  wire logic                       offset_load_select,
	input  wire logic                       replay_strobe,
	input  wire logic                       flag_sync_select,
	// depth expansion pins
	input  wire logic                       cascade_mode,
	input  wire logic                       first_device_select,
	input  wire logic                       write_chain_in,
	input  wire logic                       read_chain_in,
	output logic                            write_chain_out,
	output logic                            read_chain_out,
	// flags
	output logic                            full_flag_n,
	output logic                            empty_flag_n,
	output logic                            almost_full_flag_n,
	output logic                            almost_empty_flag_n,
	output logic                            half_full_flag_n
);
	import sfp_pkg::*;

	localparam int AW = $clog2(DEPTH);
	localparam logic [CNT_W-1:0] FULL_CNT = CNT_W'(DEPTH);
	localparam logic [CNT_W-1:0] HALF_CNT = CNT_W'(DEPTH / 2);
	localparam logic [OFF_W-1:0] OFS_DEF  = sfp_default_offset(DEPTH);

	logic [PIN_W-1:0]  pins;
	logic [PIN_W-1:0]  pins_s;
	logic              wclk_q;
	logic              rclk_q;
	logic              replay_q;
	logic              wchain_q;
	logic              rchain_q;
	logic              wr_tick;
	logic              rd_tick;
	logic              replay_tick;
	logic              wchain_tick;
	logic              rchain_tick;
	logic              clr;
	logic              osel_n;
	logic              casc;
	logic              wr_tok;
	logic              rd_tok;
	logic              ofs_wr;
	logic              ofs_rd;
	logic              wr_req;
	logic              rd_req;
	logic              replay;
	sfp_ofs_e          wr_sel;
	sfp_ofs_e          rd_sel;
	logic [OFF_W-1:0]  ae_off;
	logic [OFF_W-1:0]  af_off;
	logic [AW:0]       wr_ptr;
	logic [AW:0]       rd_ptr;
	logic [AW:0]       next_wr_ptr;
	logic [AW:0]       next_rd_ptr;
	logic [CNT_W-1:0]  next_count;
	logic [CNT_W-1:0]  af_thr;
	logic [DATA_W-1:0] mem_q;

	// every pin crosses two flops before any logic looks at it
	assign pins = {data_in, master_reset_n, cascade_mode, read_chain_in, write_chain_in,
		first_device_select, flag_sync_select, replay_strobe, offset_load_select,
		read_enable_n, write_enable_n, read_clk, write_clk};

	sfp_sync #(
		.W    (PIN_W),
		.INIT (PIN_INIT)
	) u_sync (
		.sys_clk (sys_clk),
		.resetn  (resetn),
		.pin     (pins),
		.sync    (pins_s)
	);

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wclk_q <= 1'b0;
			rclk_q <= 1'b0;
			replay_q <= 1'b0;
			wchain_q <= 1'b0;
			rchain_q <= 1'b0;
		end else begin
			wclk_q   <= pins_s[PIN_WCLK];
			rclk_q   <= pins_s[PIN_RCLK];
			replay_q <= pins_s[PIN_REPLAY];
			wchain_q <= pins_s[PIN_WCHAIN];
			rchain_q <= pins_s[PIN_RCHAIN];
		end
	end

	// the pin clocks are sampled, so each must stay high and low for over one sys_clk period
	assign wr_tick  = pins_s[PIN_WCLK] & ~wclk_q;
	assign rd_tick  = pins_s[PIN_RCLK] & ~rclk_q;
	assign replay_tick = pins_s[PIN_REPLAY] & ~replay_q;
	assign wchain_tick = pins_s[PIN_WCHAIN] & ~wchain_q;
	assign rchain_tick = pins_s[PIN_RCHAIN] & ~rchain_q;
	assign clr         = ~pins_s[PIN_MRST];
	assign osel_n      = pins_s[PIN_OSEL];
	assign casc        = pins_s[PIN_CASC];

	assign ofs_wr = wr_tick & ~osel_n & ~pins_s[PIN_WEN];
	assign ofs_rd = rd_tick & ~osel_n & ~pins_s[PIN_REN];
	assign wr_req = wr_tick & osel_n & ~pins_s[PIN_WEN] & full_flag_n & (~casc | wr_tok);
	assign rd_req = rd_tick & osel_n & ~pins_s[PIN_REN] & empty_flag_n & (~casc | rd_tok);
	assign replay = replay_tick & ~casc;

	// count seen after this cycle's write, read and replay all settle
	always_comb begin
		next_wr_ptr = wr_ptr + (AW + 1)'(wr_req);
		next_rd_ptr = replay ? '0 : rd_ptr + (AW + 1)'(rd_req);
		next_count  = CNT_W'(next_wr_ptr - next_rd_ptr);
		af_thr      = FULL_CNT - CNT_W'(af_off);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else if (clr) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
		end
	end

	sfp_mem #(
		.DEPTH (DEPTH),
		.WIDTH (DATA_W)
	) u_mem (
		.sys_clk (sys_clk),
		.wr_en   (wr_req),
		.wr_addr (wr_ptr[AW-1:0]),
		.wr_data (pins_s[PIN_DATA +: DATA_W]),
		.rd_addr (rd_ptr[AW-1:0]),
		.rd_data (mem_q)
	);

	// offset registers; the selectors survive the select going high so programming can resume
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ae_off <= OFS_DEF;
			af_off <= OFS_DEF;
			wr_sel <= OFS_EMPTY;
		end else if (clr) begin
			ae_off <= OFS_DEF;
			af_off <= OFS_DEF;
			wr_sel <= OFS_EMPTY;
		end else if (ofs_wr) begin
			case (wr_sel)
				OFS_EMPTY: begin
					ae_off <= pins_s[PIN_DATA +: OFF_W];
					wr_sel <= OFS_FULL;
				end
				OFS_FULL: begin
					af_off <= pins_s[PIN_DATA +: OFF_W];
					wr_sel <= OFS_EMPTY;
				end
				default: wr_sel <= OFS_EMPTY;
			endcase
		end
	end

	// output word: offset readback or fifo data; otherwise held
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			data_out <= '0;
			rd_sel   <= OFS_EMPTY;
		end else if (clr) begin
			data_out <= '0;
			rd_sel   <= OFS_EMPTY;
		end else if (ofs_rd) begin
			case (rd_sel)
				OFS_EMPTY: begin
					data_out <= DATA_W'(ae_off);
					rd_sel   <= OFS_FULL;
				end
				OFS_FULL: begin
					data_out <= DATA_W'(af_off);
					rd_sel   <= OFS_EMPTY;
				end
				default: rd_sel <= OFS_EMPTY;
			endcase
		end else if (rd_req) begin
			data_out <= mem_q;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			full_flag_n  <= 1'b1;
			empty_flag_n <= 1'b0;
		end else if (clr) begin
			full_flag_n  <= 1'b1;
			empty_flag_n <= 1'b0;
		end else begin
			if (wr_tick)
				full_flag_n <= (next_count != FULL_CNT);
			if (rd_tick | replay)
				empty_flag_n <= (next_count != '0);
		end
	end

	// flag_sync_select high: almost flags follow the count every cycle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
			half_full_flag_n    <= 1'b1;
		end else if (clr) begin
			almost_empty_flag_n <= 1'b0;
			almost_full_flag_n  <= 1'b1;
			half_full_flag_n    <= 1'b1;
		end else begin
			if (pins_s[PIN_FSYNC] | rd_tick | replay)
				almost_empty_flag_n <= (next_count > CNT_W'(ae_off));
			if (pins_s[PIN_FSYNC] | wr_tick)
				almost_full_flag_n <= (next_count < af_thr);
			half_full_flag_n <= casc | (next_count <= HALF_CNT);
		end
	end

	// depth chain: a device owns writes (reads) until it fills (drains), then hands on
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wr_tok          <= 1'b0;
			rd_tok          <= 1'b0;
			write_chain_out <= 1'b0;
			read_chain_out  <= 1'b0;
		end else if (clr) begin
			wr_tok          <= ~pins_s[PIN_FIRST];
			rd_tok          <= ~pins_s[PIN_FIRST];
			write_chain_out <= 1'b0;
			read_chain_out  <= 1'b0;
		end else begin
			write_chain_out <= casc & wr_req & (next_count == FULL_CNT);
			read_chain_out  <= casc & rd_req & (next_count == '0);
			if (wchain_tick)
				wr_tok <= 1'b1;
			else if (wr_req & (next_count == FULL_CNT))
				wr_tok <= 1'b0;
			if (rchain_tick)
				rd_tok <= 1'b1;
			else if (rd_req & (next_count == '0))
				rd_tok <= 1'b0;
		end
	end

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	ofs_load_a: assert property (
		!clr && ofs_wr && wr_sel == OFS_EMPTY
		|=> ae_off == $past(pins_s[PIN_DATA +: OFF_W]) && wr_sel == OFS_FULL)
		else $error("empty offset not loaded");
	ofs_resume_a: assert property (
		!clr && !ofs_wr
		|=> wr_sel == $past(wr_sel))
		else $error("offset selector moved without a load");
	ofs_readback_a: assert property (
		!clr && ofs_rd && rd_sel == OFS_EMPTY
		|=> data_out == DATA_W'($past(ae_off)) && rd_sel == OFS_FULL)
		else $error("empty offset not read back");
	full_block_a: assert property (
		!clr && !full_flag_n
		|=> wr_ptr == $past(wr_ptr))
		else $error("write taken while full");
	full_edge_a: assert property (
		!clr && !wr_tick ##1 !clr
		|-> $stable(full_flag_n))
		else $error("full flag moved off a write edge");
	empty_block_a: assert property (
		!clr && !empty_flag_n && !replay
		|=> rd_ptr == $past(rd_ptr) && $stable(data_out) || $past(ofs_rd))
		else $error("read taken while empty");
	empty_edge_a: assert property (
		!clr && !rd_tick && !replay ##1 !clr
		|-> $stable(empty_flag_n))
		else $error("empty flag moved off a read edge");
	ae_level_a: assert property (
		!clr && pins_s[PIN_FSYNC]
		|=> almost_empty_flag_n == ($past(next_count) > CNT_W'($past(ae_off))))
		else $error("almost empty level wrong");
	af_edge_a: assert property (
		!clr && !pins_s[PIN_FSYNC] && !wr_tick ##1 !clr
		|-> $stable(almost_full_flag_n))
		else $error("almost full moved off a write edge");
	ae_edge_a: assert property (
		!clr && !pins_s[PIN_FSYNC] && !rd_tick && !replay ##1 !clr
		|-> $stable(almost_empty_flag_n))
		else $error("almost empty moved off a read edge");
	half_level_a: assert property (
		!clr && !casc
		|=> half_full_flag_n == ($past(next_count) <= HALF_CNT))
		else $error("half full level wrong");
	chain_half_a: assert property (
		!clr && casc
		|=> half_full_flag_n)
		else $error("half flag shown in depth chain");
	replay_ptr_a: assert property (
		!clr && replay
		|=> rd_ptr == '0 && wr_ptr == $past(next_wr_ptr))
		else $error("replay did not rewind read pointer");
	reset_empty_a: assert property (
		clr
		|=> !empty_flag_n && rd_ptr == wr_ptr)
		else $error("master reset did not empty");

	ofs_prog_c: cover property (ofs_wr ##[1:40] ofs_wr);
	ofs_read_c: cover property (ofs_rd ##[1:40] ofs_rd);
	fill_up_c: cover property (!full_flag_n);
	chain_fill_c: cover property (write_chain_out);
	replay_c: cover property (replay ##[1:60] rd_req);
endmodule

// file: dv/sfp_host.sv
// partner model: system logic driving the fifo pins
module sfp_host
	import sfp_pkg::*;
(
	// clock
	input  wire logic                       sys_clk,
	// fifo pins
	output logic                            write_clk,
	output logic                            read_clk,
	output logic                            write_enable_n,
	output logic                            read_enable_n,
	output logic                            offset_load_select,
	output logic                            replay_strobe,
	output logic                            master_reset_n,
	output logic      [sfp_pkg::DATA_W-1:0] data_in
);
	timeunit 1ns;
	timeprecision 1ns;

	initial begin
		write_clk = 1'b0;
		read_clk = 1'b0;
		write_enable_n = 1'b1;
		read_enable_n = 1'b1;
		offset_load_select = 1'b1;
		replay_strobe = 1'b0;
		master_reset_n = 1'b0;
		data_in = 18'h15555;
	end

	// one clock pulse on both pins; pins are sampled, so 4 cycles high and 4 low
	task automatic cyc(input logic w, input logic r, input logic osel, input logic [DATA_W-1:0] d);
		@(negedge sys_clk);
		offset_load_select <= osel;
		write_enable_n <= !w;
		read_enable_n <= !r;
		data_in <= d;
		@(negedge sys_clk);
		write_clk <= 1'b1;
		read_clk <= 1'b1;
		repeat (4) @(negedge sys_clk);
		write_clk <= 1'b0;
		read_clk <= 1'b0;
		repeat (4) @(negedge sys_clk);
		write_enable_n <= 1'b1;
		read_enable_n <= 1'b1;
		offset_load_select <= 1'b1;
		// released data shows a changed pattern, not the stale word
		data_in <= ~d;
	endtask

	task automatic mreset();
		@(negedge sys_clk);
		master_reset_n <= 1'b0;
		repeat (6) @(negedge sys_clk);
		master_reset_n <= 1'b1;
		repeat (6) @(negedge sys_clk);
	endtask

	// enables stay high through the strobe and its recovery time
	task automatic replay();
		@(negedge sys_clk);
		replay_strobe <= 1'b1;
		repeat (4) @(negedge sys_clk);
		replay_strobe <= 1'b0;
		repeat (8) @(negedge sys_clk);
	endtask
endmodule

// file: dv/sfp_fifo_test.sv
// self-checking bench for the programmable-flag fifo
module sfp_fifo_test;
	timeunit 1ns;
	timeprecision 1ns;
	import sfp_pkg::*;
	localparam int DEPTH = 64;

	logic              sys_clk;
	logic              resetn;
	logic              write_clk;
	logic              read_clk;
	logic              write_enable_n;
	logic              read_enable_n;
	logic              offset_load_select;
	logic              replay_strobe;
	logic              master_reset_n;
	logic [DATA_W-1:0] data_in;
	logic [DATA_W-1:0] data_out;
	logic              full_flag_n;
	logic              empty_flag_n;
	logic              almost_full_flag_n;
	logic              almost_empty_flag_n;
	logic              half_full_flag_n;
	logic              flag_sync_select;
	logic              cascade_mode;
	logic              first_device_select;
	logic              write_chain_in;
	logic              read_chain_in;
	logic              write_chain_out;
	logic              read_chain_out;
	int                err_count;
	int                tests_run;
	int                ae_ofs;
	int                af_ofs;
	int                wchain_cnt = 0;
	int                rchain_cnt = 0;

	sfp_host i_sfp_host (
		.sys_clk            (sys_clk),
		.write_clk          (write_clk),
		.read_clk           (read_clk),
		.write_enable_n     (write_enable_n),
		.read_enable_n      (read_enable_n),
		.offset_load_select (offset_load_select),
		.replay_strobe      (replay_strobe),
		.master_reset_n     (master_reset_n),
		.data_in            (data_in)
	);

	sfp_fifo #(.DEPTH(DEPTH)) i_sfp_fifo (
		.sys_clk             (sys_clk),
		.resetn              (resetn),
		.write_clk           (write_clk),
		.write_enable_n      (write_enable_n),
		.data_in             (data_in),
		.read_clk            (read_clk),
		.read_enable_n       (read_enable_n),
		.data_out            (data_out),
		.master_reset_n      (master_reset_n),
		.offset_load_select  (offset_load_select),
		.replay_strobe       (replay_strobe),
		.flag_sync_select    (flag_sync_select),
		.cascade_mode        (cascade_mode),
		.first_device_select (first_device_select),
		.write_chain_in      (write_chain_in),
		.read_chain_in       (read_chain_in),
		.write_chain_out     (write_chain_out),
		.read_chain_out      (read_chain_out),
		.full_flag_n         (full_flag_n),
		.empty_flag_n        (empty_flag_n),
		.almost_full_flag_n  (almost_full_flag_n),
		.almost_empty_flag_n (almost_empty_flag_n),
		.half_full_flag_n    (half_full_flag_n)
	);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	// chain pulses last one sys_clk, so every falling edge sees each exactly once
	always @(negedge sys_clk) begin
		if (write_chain_out === 1'b1)
			wchain_cnt <= wchain_cnt + 1;
		if (read_chain_out === 1'b1)
			rchain_cnt <= rchain_cnt + 1;
	end

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// order: full, almost full, half, almost empty, empty
	function automatic logic [4:0] exp_flags(input int n);
		return {n < DEPTH, n < DEPTH - af_ofs, n <= DEPTH / 2, n > ae_ofs, n != 0};
	endfunction

	task automatic chk_flags(input int n);
		check("flags", {27'h0, full_flag_n, almost_full_flag_n, half_full_flag_n,
			almost_empty_flag_n, empty_flag_n}, {27'h0, exp_flags(n)});
	endtask

	task automatic rd_word(input logic [DATA_W-1:0] exp, input int n);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b1, 18'h0);
		check("data_out", {14'h0, data_out}, {14'h0, exp});
		chk_flags(n);
	endtask

	task automatic t_defaults();
		ae_ofs = 7;
		af_ofs = 7;
		chk_flags(0);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b0, 18'h0);
		check("ae default", {14'h0, data_out}, 32'h7);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b0, 18'h0);
		check("af default", {14'h0, data_out}, 32'h7);
	endtask

	// load empty offset, leave programming, no-op edge, then resume at full offset
	task automatic t_offsets();
		i_sfp_host.cyc(1'b1, 1'b0, 1'b0, 18'h3F003);
		i_sfp_host.cyc(1'b0, 1'b0, 1'b1, 18'h0);
		i_sfp_host.cyc(1'b0, 1'b0, 1'b0, 18'h00009);
		i_sfp_host.cyc(1'b1, 1'b0, 1'b0, 18'h2A005);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b0, 18'h0);
		check("ae offset", {14'h0, data_out}, 32'h3);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b0, 18'h0);
		check("af offset", {14'h0, data_out}, 32'h5);
		ae_ofs = 3;
		af_ofs = 5;
		chk_flags(0);
	endtask

	task automatic t_fill_drain();
		for (int i = 1; i <= DEPTH; i++) begin
			i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'(i));
			chk_flags(i);
		end
		i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'h3FFFF);
		chk_flags(DEPTH);
		for (int i = 1; i <= DEPTH; i++)
			rd_word(18'(i), DEPTH - i);
		rd_word(18'(DEPTH), 0);
	endtask

	// rewind after partial read, then a word written after the strobe follows
	task automatic t_replay();
		i_sfp_host.mreset();
		ae_ofs = 7;
		af_ofs = 7;
		chk_flags(0);
		for (int i = 0; i < 5; i++)
			i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'(16 + i));
		rd_word(18'h10, 4);
		rd_word(18'h11, 3);
		i_sfp_host.replay();
		chk_flags(5);
		i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'h15);
		for (int i = 0; i < 6; i++)
			rd_word(18'(16 + i), 5 - i);
	endtask

	// almost flags free-running from here on
	task automatic t_simul();
		@(negedge sys_clk);
		flag_sync_select <= 1'b1;
		i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'h20);
		i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'h21);
		i_sfp_host.cyc(1'b1, 1'b1, 1'b1, 18'h22);
		check("simul read", {14'h0, data_out}, 32'h20);
		chk_flags(2);
		rd_word(18'h21, 1);
		rd_word(18'h22, 0);
	endtask

	// second device of a depth chain: idle until handed the tokens, then one fill and one drain
	task automatic t_cascade();
		@(negedge sys_clk);
		cascade_mode <= 1'b1;
		first_device_select <= 1'b1;
		i_sfp_host.mreset();
		i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'h30);
		check("write without token", {31'h0, empty_flag_n}, 32'h0);
		write_chain_in <= 1'b1;
		read_chain_in <= 1'b1;
		repeat (4) @(negedge sys_clk);
		write_chain_in <= 1'b0;
		read_chain_in <= 1'b0;
		for (int i = 1; i <= DEPTH; i++)
			i_sfp_host.cyc(1'b1, 1'b0, 1'b1, 18'(i));
		check("chain half flag", {31'h0, half_full_flag_n}, 32'h1);
		check("write chain pulses", wchain_cnt, 32'h1);
		i_sfp_host.cyc(1'b0, 1'b1, 1'b1, 18'h0);
		check("chain first word", {14'h0, data_out}, 32'h1);
		i_sfp_host.replay();
		for (int i = 2; i <= DEPTH; i++) begin
			i_sfp_host.cyc(1'b0, 1'b1, 1'b1, 18'h0);
			check("chain data", {14'h0, data_out}, 32'(i));
		end
		check("read chain pulses", rchain_cnt, 32'h1);
	endtask

	initial begin
		repeat (100000) @(posedge sys_clk);
		err_count++;
		stop_test();
	end

	initial begin
		err_count = 0;
		tests_run = 0;
		resetn = 1'b0;
		flag_sync_select = 1'b0;
		cascade_mode = 1'b0;
		first_device_select = 1'b0;
		write_chain_in = 1'b0;
		read_chain_in = 1'b0;
		repeat (5) @(negedge sys_clk);
		resetn <= 1'b1;
		i_sfp_host.mreset();
		t_defaults();
		t_offsets();
		t_fill_drain();
		t_replay();
		t_simul();
		t_cascade();
		stop_test();
	end
endmodule
